// *** common/psd_regs.svh ***
/*
  Constants of the post-scale divider block: counter count, scan chain
  layout, reset values and register word indices.
  Assumes it is included by its bare name and defines nothing else.
*/
`ifndef PSD_REGS_SVH
`define PSD_REGS_SVH

// Number of post-scale counters
`define PSD_NUM_CNT 5
// Bits of one counter's setting in the scan chain
`define PSD_CFG_W 18
// Whole scan chain, five settings
`define PSD_CHAIN_W 90
// Field positions inside one setting
`define PSD_HI_MSB 17
`define PSD_HI_LSB 10
`define PSD_LO_MSB 9
`define PSD_LO_LSB 2
`define PSD_BYP_BIT 1
`define PSD_ODD_BIT 0
// Reset setting: high 1, low 1, no bypass, even
`define PSD_CFG_RST 18'h00404
// Reset of the output enables
`define PSD_OE_RST 5'h1F
// Register word indices
`define PSD_ADDR_CTRL 4'h0
`define PSD_ADDR_STATUS 4'h1
`define PSD_ADDR_CFG0 4'h2

`endif

// *** common/psd_pkg.sv ***
/*
  Types of the post-scale divider block.
  Assumes the constants header is compiled alongside.
*/
package psd_pkg;

  // Scan load sequence; one bit flips per step except IDLE to APPLY and APPLY back to IDLE
  typedef enum logic [1:0] {
    PSD_IDLE = 2'b00,
    PSD_SHIFT = 2'b01,
    PSD_APPLY = 2'b11
  } psd_scan_state_t;

  // Register word index
  typedef logic [3:0] psd_addr_t;

  // Counter select of the phase step port
  typedef logic [2:0] psd_sel_t;

endpackage : psd_pkg

// *** rtl/psd_top.sv ***
/*
  Post-scale divider with run-time reload: five counters divide the
  VCO clock, a scan port reloads their settings, a phase step port
  nudges each output that is not bypassed by one VCO cycle, and a small
  register port gates outputs and shows state.
  Assumes sys_clk_i is the VCO clock and all control inputs come from
  logic on that clock.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "psd_regs.svh"

module psd_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scan_shift_i,
  input wire logic scan_data_i,
  input wire logic scan_update_i,
  output logic scan_done_o,
  input wire logic phase_step_i,
  input wire psd_pkg::psd_sel_t phase_sel_i,
  input wire logic phase_up_i,
  output logic phase_done_o,
  input wire psd_pkg::psd_addr_t reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic [4:0] out_clk_o
);
  import psd_pkg::*;

  // Shadow chain filled by the scan port
  logic [`PSD_CHAIN_W-1:0] chain_reg;
  // Settings the counters run on
  logic [`PSD_CHAIN_W-1:0] active_reg;
  // Scan load sequence
  psd_scan_state_t state_reg;
  psd_scan_state_t state_next;
  // Apply cycle of the sequence
  logic apply_w;
  // Counters restart one cycle after apply
  logic restart_reg;
  // Done pulses
  logic scan_done_reg;
  logic phase_done_reg;
  // Output enables, software written
  logic [4:0] oe_reg;
  // Number of completed reloads
  logic [7:0] upd_cnt_reg;
  // Read data and its next value
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Phase steps waiting, and their direction
  logic [4:0] pend_reg;
  logic [4:0] dir_reg;
  // Phase step taken by a counter this cycle
  logic [4:0] adj_w;
  // Step accepted from the port this cycle
  logic [4:0] take_w;
  // Counter output levels, rising and falling edge copies
  logic [4:0] pos_reg;
  logic [4:0] neg_reg;

  assign apply_w = (state_reg == PSD_APPLY);

  // Next state of the scan load
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      // Wait for shifting or an update
      PSD_IDLE:
      begin
        if (scan_update_i)
          state_next = PSD_APPLY;
        else if (scan_shift_i)
          state_next = PSD_SHIFT;
      end
      // Chain filling; update ends it
      PSD_SHIFT:
      begin
        if (scan_update_i)
          state_next = PSD_APPLY;
      end
      // One cycle of transfer
      PSD_APPLY:
        state_next = PSD_IDLE;
      // Unused code returns to idle
      default:
        state_next = PSD_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= PSD_IDLE;
    else if (ce_i)
      state_reg <= state_next;
  end

  // Shadow chain shifts in one bit per shift cycle, all fields of every setting
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      chain_reg <= {`PSD_NUM_CNT{`PSD_CFG_RST}};
    else if (ce_i && scan_shift_i)
      chain_reg <= {chain_reg[`PSD_CHAIN_W-2:0], scan_data_i};
  end

  // Whole chain moves to the counters at once
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      active_reg <= {`PSD_NUM_CNT{`PSD_CFG_RST}};
    else if (ce_i && apply_w)
      active_reg <= chain_reg;
  end

  // Restart strobe and done pulse follow the apply cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      restart_reg <= 1'b0;
      scan_done_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      restart_reg <= apply_w;
      scan_done_reg <= apply_w;
    end
  end

  // Reload counter for software
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      upd_cnt_reg <= 8'h00;
    else if (ce_i && apply_w)
      upd_cnt_reg <= upd_cnt_reg + 8'h01;
  end

  // Phase done pulse when any counter takes its step
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      phase_done_reg <= 1'b0;
    else if (ce_i)
      phase_done_reg <= |adj_w;
  end

  // Output enables written by software
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      oe_reg <= `PSD_OE_RST;
    else if (ce_i && reg_we_i && reg_addr_i == `PSD_ADDR_CTRL)
      oe_reg <= reg_wdata_i[4:0];
  end

  // Read multiplexer; unmapped words read zero
  always_comb
  begin
    rdata_next = 32'h00000000;
    if (reg_re_i)
    begin
      if (reg_addr_i == `PSD_ADDR_CTRL)
        rdata_next = {27'h0000000, oe_reg};
      else if (reg_addr_i == `PSD_ADDR_STATUS)
        rdata_next = {16'h0000, upd_cnt_reg, 3'h0, pend_reg};
      for (int k = 0; k < `PSD_NUM_CNT; k++)
      begin
        // Running setting of counter k
        if (reg_addr_i == 4'(`PSD_ADDR_CFG0 + k))
          rdata_next = {14'h0000, active_reg[k*`PSD_CFG_W +: `PSD_CFG_W]};
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h00000000;
    else if (ce_i)
      rdata_reg <= rdata_next;
  end

  // One block per post-scale counter
  genvar gi;
  generate
    for (gi = 0; gi < `PSD_NUM_CNT; gi++)
    begin : g_cnt
      // This counter's running setting
      logic [`PSD_CFG_W-1:0] cfg_w;
      logic [7:0] hi_w;
      logic [7:0] lo_w;
      logic byp_w;
      logic odd_w;
      // Phase lengths in VCO cycles
      logic [8:0] hl_w;
      logic [8:0] ll_w;
      // Down counter of the current phase
      logic [8:0] cnt_reg;
      logic term_w;
      // Run length helper and its validity
      logic [8:0] run_reg;
      logic clean_reg;

      assign cfg_w = active_reg[gi*`PSD_CFG_W +: `PSD_CFG_W];
      assign hi_w = cfg_w[`PSD_HI_MSB:`PSD_HI_LSB];
      assign lo_w = cfg_w[`PSD_LO_MSB:`PSD_LO_LSB];
      assign byp_w = cfg_w[`PSD_BYP_BIT];
      assign odd_w = cfg_w[`PSD_ODD_BIT];
      assign term_w = (cnt_reg == 9'h001);
      assign take_w[gi] = phase_step_i && !pend_reg[gi] &&
                          (phase_sel_i == 3'(gi));

      // Lengths; odd mode moves one cycle from high to low
      always_comb
      begin
        if (odd_w)
        begin
          hl_w = (hi_w <= 8'h02) ? 9'h001 : {1'b0, hi_w} - 9'h001;
          ll_w = {1'b0, lo_w} + 9'h001;
        end
        else
        begin
          hl_w = (hi_w == 8'h00) ? 9'h001 : {1'b0, hi_w};
          ll_w = (lo_w == 8'h00) ? 9'h001 : {1'b0, lo_w};
        end
      end

      // Pending step taken mid-phase; advance needs room for two
      assign adj_w[gi] = pend_reg[gi] && !term_w && !restart_reg &&
                         (dir_reg[gi] || cnt_reg > 9'h002);

      // Phase step request of this counter
      always_ff @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          pend_reg[gi] <= 1'b0;
          dir_reg[gi] <= 1'b0;
        end
        else if (ce_i)
        begin
          // Taking clears; a busy counter refuses new steps
          if (adj_w[gi])
            pend_reg[gi] <= 1'b0;
          else if (take_w[gi])
          begin
            pend_reg[gi] <= 1'b1;
            dir_reg[gi] <= phase_up_i;
          end
        end
      end

      // High and low phase counting on VCO rising edges
      always_ff @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          cnt_reg <= 9'h001;
          pos_reg[gi] <= 1'b0;
        end
        else if (ce_i)
        begin
          // Fresh settings start a high phase
          if (restart_reg)
          begin
            cnt_reg <= hl_w;
            pos_reg[gi] <= 1'b1;
          end
          // End of phase flips level, loads other length
          else if (term_w)
          begin
            pos_reg[gi] <= !pos_reg[gi];
            cnt_reg <= pos_reg[gi] ? ll_w : hl_w;
          end
          // Delay holds one cycle, advance skips one
          else if (adj_w[gi])
            cnt_reg <= dir_reg[gi] ? cnt_reg : cnt_reg - 9'h002;
          else
            cnt_reg <= cnt_reg - 9'h001;
        end
      end

      // Falling edge copy stretches high by half a cycle
      always_ff @(negedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
          neg_reg[gi] <= 1'b0;
        else if (ce_i)
          neg_reg[gi] <= pos_reg[gi];
      end

      // Run length of the current level
      always_ff @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          run_reg <= 9'h001;
          clean_reg <= 1'b0;
        end
        else if (ce_i)
        begin
          run_reg <= (restart_reg || term_w) ? 9'h001 : run_reg + 9'h001;
          if (restart_reg || adj_w[gi])
            clean_reg <= 1'b0;
          else if (term_w)
            clean_reg <= 1'b1;
        end
      end

      // Bypass passes the VCO; odd adds the falling edge copy
      assign out_clk_o[gi] = oe_reg[gi] &
        (byp_w ? sys_clk_i : (pos_reg[gi] | (odd_w & neg_reg[gi])));

      a_high_time: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && term_w && pos_reg[gi] && clean_reg && !restart_reg
        |-> run_reg == hl_w)
        else $error("high phase length wrong");

      a_low_time: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && term_w && !pos_reg[gi] && clean_reg && !restart_reg
        |-> run_reg == ll_w)
        else $error("low phase length wrong");

      // Copy held high through the half cycle before the fall
      a_odd_extend: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && $fell(pos_reg[gi]) |-> $past(neg_reg[gi]))
        else $error("falling edge copy missing");
    end
  endgenerate

  assign scan_done_o = scan_done_reg;
  assign phase_done_o = phase_done_reg;
  assign reg_rdata_o = rdata_reg;

  a_apply_full: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !$stable(active_reg) |-> $past(state_reg) == PSD_APPLY)
    else $error("settings changed outside apply");

  a_apply_copy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && state_reg == PSD_APPLY |=> active_reg == $past(chain_reg))
    else $error("apply did not copy chain");

  a_phase_done: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && (|take_w) |-> ##[1:600] phase_done_reg)
    else $error("phase step never taken");

  a_read_ctrl: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && reg_re_i && reg_addr_i == `PSD_ADDR_CTRL
    |=> reg_rdata_o == {27'h0000000, $past(oe_reg)})
    else $error("control readback wrong");

  a_count_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && state_reg == PSD_APPLY |=> upd_cnt_reg == $past(upd_cnt_reg) + 8'h01)
    else $error("reload count not stepped");

endmodule : psd_top

// *** tb/psd_scan_src.sv ***
/*
  Scan source standing in for the reload controller logic.
  Assumes it shares the divider clock and sees go_i as a one-cycle pulse.
*/
`timescale 1ns/1ps
module psd_scan_src (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [89:0] chain_i,
  output logic shift_o = 1'b0,
  output logic data_o = 1'b0,
  output logic update_o = 1'b0
);
  logic [6:0] cnt_reg = 7'h00; // Bits left to send
  logic [89:0] sh_reg = '0; // Chain, top bit leaves first
  logic gap_reg = 1'b0; // Idle slot in slow mode
  logic last_reg = 1'b0; // Last bit went out
  // Whole chain first, update one cycle after the last bit
  always @(posedge clk_i)
  begin
    gap_reg <= slow_i & ~gap_reg;
    last_reg <= 1'b0;
    update_o <= last_reg;
    shift_o <= 1'b0;
    data_o <= ~data_o; // Line not held when idle
    if (go_i)
    begin
      sh_reg <= chain_i;
      cnt_reg <= 7'h5A;
    end
    else if (cnt_reg != 7'h00 && !gap_reg)
    begin
      shift_o <= 1'b1;
      data_o <= sh_reg[89];
      sh_reg <= sh_reg << 1;
      cnt_reg <= cnt_reg - 7'h01;
      last_reg <= (cnt_reg == 7'h01);
    end
  end
endmodule : psd_scan_src

// *** tb/pll_post_scale_divider_reconfig_tb_top.sv ***
/*
  Bench of the post-scale divider: reloads, output timing, phase steps.
  Assumes the divider top and the scan source are compiled before it.
*/
`timescale 1ns/1ps
`include "psd_regs.svh"
module pll_post_scale_divider_reconfig_tb_top;
  import psd_pkg::*;
  logic clk = 1'b0; // 200 MHz
  logic rst = 1'b1;
  logic ce = 1'b1; // Clock enable of the divider
  logic shift, sdata, upd, done, ph_done;
  logic step = 1'b0, up = 1'b0, re = 1'b0, we = 1'b0, go = 1'b0, slow = 1'b0;
  psd_sel_t sel = 3'h0;
  psd_addr_t addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [4:0] oclk;
  logic [89:0] chain = '0;
  logic [17:0] cfg [5]; // Expected settings
  logic [31:0] lfsr = 32'h109D;
  int error_cnt = 0, tests_run = 0;
  // Clock
  always #2.5 clk = ~clk;
  psd_top u_psd_top (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .scan_shift_i(shift),
    .scan_data_i(sdata), .scan_update_i(upd), .scan_done_o(done), .phase_step_i(step),
    .phase_sel_i(sel), .phase_up_i(up), .phase_done_o(ph_done), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .out_clk_o(oclk));
  psd_scan_src u_psd_scan_src (.clk_i(clk), .go_i(go), .slow_i(slow), .chain_i(chain),
    .shift_o(shift), .data_o(sdata), .update_o(upd));
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_step
  // Expected high and low half-cycles of one output period
  function automatic logic [31:0] exp_len(input logic [17:0] c);
    logic [15:0] h, l;
    h = (c[17:10] == 8'h00) ? 16'h2 : {7'h0, c[17:10], 1'b0};
    l = (c[9:2] == 8'h00) ? 16'h2 : {7'h0, c[9:2], 1'b0};
    if (c[`PSD_BYP_BIT])
      return 32'h00010001;
    if (c[`PSD_ODD_BIT])
      return {h - 16'h1, l + 16'h1};
    return {h, l};
  endfunction : exp_len
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic give_up();
    error_cnt++;
    final_report();
  endtask : give_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp
  task automatic reg_rd(input psd_addr_t a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    rd = rdata;
  endtask : reg_rd
  task automatic reg_wr(input psd_addr_t a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : reg_wr
  // Bounded wait for a done pulse
  task automatic wait_pulse(input bit ph, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      if ((ph ? ph_done : done) === 1'b1)
        return;
    end
    give_up();
  endtask : wait_pulse
  task automatic half(inout int c);
    @(clk);
    #1.25;
    c++;
  endtask : half
  // Half-cycle counts of one period of output k
  task automatic meas(input int k, output int nh, output int nl);
    int w;
    w = 0;
    nh = 0;
    nl = 0;
    while (oclk[k] !== 1'b0 && w < 1100) half(w);
    while (oclk[k] !== 1'b1 && w < 2200) half(w);
    while (oclk[k] === 1'b1 && nh < 1100) half(nh);
    while (oclk[k] === 1'b0 && nl < 1100) half(nl);
    if (w >= 2200 || nh >= 1100 || nl >= 1100)
      give_up();
  endtask : meas
  initial
  begin
    logic [17:0] prev;
    int nh, nl;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_rd(`PSD_ADDR_CTRL);
    cmp(rd, 32'h1F);
    reg_wr(`PSD_ADDR_CFG0, 32'h3FFFF);
    reg_rd(4'hF);
    cmp(rd, 32'h0);
    for (int k = 0; k < 5; k++) cfg[k] = `PSD_CFG_RST;
    // Reset settings, then five reloads: corners, random, aligned
    for (int n = 0; n < 6; n++)
    begin
      for (int k = 0; k < 5; k++)
      begin
        reg_rd(`PSD_ADDR_CFG0 + 4'(k));
        cmp(rd, {14'h0, cfg[k]});
        meas(k, nh, nl);
        cmp({nh[15:0], nl[15:0]}, exp_len(cfg[k]));
      end
      reg_rd(`PSD_ADDR_STATUS);
      cmp({rd[15:8], rd[4:0]}, {8'(n), 5'h0});
      if (n == 5)
        break;
      prev = cfg[0];
      for (int k = 0; k < 5; k++)
      begin
        lfsr = lfsr_step(lfsr);
        cfg[k] = {8'h2 + lfsr[2:0], 8'h1 + lfsr[5:3], lfsr[8] & lfsr[9], lfsr[10]};
        if (n == 4)
          cfg[k] = {8'h04, 8'h04, 2'b00};
      end
      if (n == 0)
      begin
        cfg[0] = {8'h02, 8'h01, 2'b01};
        cfg[1] = {8'h05, 8'h05, 2'b10};
        cfg[2] = {8'hFF, 8'hFF, 2'b00};
        cfg[3] = {8'h04, 8'h06, 2'b00};
      end
      for (int k = 0; k < 5; k++) chain[18 * k +: 18] <= cfg[k];
      slow <= n[0];
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (40) @(posedge clk);
      reg_rd(`PSD_ADDR_CFG0);
      cmp(rd, {14'h0, prev});
      wait_pulse(1'b0, 400);
    end
    // Phase steps after the reload: bad select, delay, advance
    for (int d = 0; d < 3; d++)
    begin
      @(posedge clk);
      step <= 1'b1;
      sel <= (d == 0) ? 3'h5 : 3'h0;
      up <= (d == 1);
      @(posedge clk);
      step <= 1'b0;
      if (d == 0)
        reg_rd(`PSD_ADDR_STATUS);
      else
        wait_pulse(1'b1, 600);
      repeat (20) @(posedge clk);
      nh = 0;
      for (int i = 0; i < 16; i++)
      begin
        @(posedge clk);
        #1;
        nh += int'(oclk[0] !== oclk[1]);
      end
      cmp(nh, (d == 1) ? 4 : 0);
      reg_rd(`PSD_ADDR_CFG0);
      cmp(rd, {14'h0, cfg[0]});
    end
    // Output gating
    reg_wr(`PSD_ADDR_CTRL, 32'h3);
    nl = 0;
    for (int i = 0; i < 16; i++)
    begin
      half(nh);
      nl += int'(oclk[4:2] !== 3'h0);
    end
    cmp(nl, 0);
    // Clock enable low freezes counter 0
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    prev[0] = oclk[0];
    nh = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      #1;
      nh += int'(oclk[0] !== prev[0]);
    end
    cmp(nh, 0);
    @(posedge clk);
    ce <= 1'b1;
    final_report();
  end
endmodule : pll_post_scale_divider_reconfig_tb_top
